//--- hdl/cpu_core.v
// cpu_core - fetch, decode and execute sequencer of the 8-bit core
// assumes code, xdata and sfr devices on the same clock, async-read style
`timescale 1ns/10ps
`default_nettype none
`include "cpu_consts.vh"

module cpu_core (
    input  wire        clk,
    input  wire        reset_n,
    input  wire [23:0] irq_req,
    input  wire [23:0] irq_enable,
    input  wire        irq_global_enable,
    input  wire [47:0] irq_priority,
    input  wire        irq_four_level,
    output wire [15:0] code_addr,
    output wire        code_rd,
    output wire        code_wr,
    output wire [7:0]  code_wdata,
    input  wire [7:0]  code_rdata,
    input  wire        code_ready,
    output wire        code_addr_backed,
    output wire [15:0] xdata_addr,
    output wire        xdata_rd,
    output wire        xdata_wr,
    output wire [7:0]  xdata_wdata,
    input  wire [7:0]  xdata_rdata,
    input  wire        xdata_ready,
    output wire [7:0]  sfr_addr,
    output wire        sfr_rd,
    output wire        sfr_wr,
    output wire [7:0]  sfr_wdata,
    input  wire [7:0]  sfr_rdata,
    output wire        mcycle_phase,
    output wire        opcode_fetch,
    output wire [3:0]  irq_active
);

    function [1:0] instr_len;
        input [7:0] op;
        begin
            case (op)
                `OP_LJMP, `OP_MOV_D_IMM, `OP_MOV_DATA_POINTER: instr_len = 2'd3;
                `OP_MOV_A_IMM, `OP_MOV_A_DIR, `OP_MOV_DIR_A,
                `OP_SETB, `OP_CLR: instr_len = 2'd2;
                default: instr_len = 2'd1;
            endcase
        end
    endfunction

    function [2:0] instr_mcycles;
        input [7:0] op;
        begin
            case (op)
                `OP_MUL: instr_mcycles = 3'd4;
                `OP_LJMP, `OP_RETI, `OP_MOV_D_IMM, `OP_MOV_DATA_POINTER,
                `OP_INC_DATA_POINTER, `OP_MOVC_DATA_POINTER, `OP_MOVC_PC,
                `OP_CODE_STORE: instr_mcycles = 3'd2;
                default: begin
                    // movx forms E0 E2 E3 F0 F2 F3 take two cycles
                    if (op[7:5] == 3'b111 && !op[3] && !op[2] &&
                        (op[1] || !op[0]))
                        instr_mcycles = 3'd2;
                    else
                        instr_mcycles = 3'd1;
                end
            endcase
        end
    endfunction

    function is_core_sfr;
        input [7:0] a;
        begin
            is_core_sfr = (a == `SFR_ACC) || (a == `SFR_B) ||
                          (a == `SFR_PSW) || (a == `SFR_SP) ||
                          (a == `SFR_DPL) || (a == `SFR_DPH);
        end
    endfunction

    reg  [2:0]  cnt_q;
    reg  [7:0]  opcode_q;
    reg  [7:0]  op1_q;
    reg  [7:0]  op2_q;
    reg  [15:0] pc_q;
    reg  [7:0]  acc_q;
    reg  [7:0]  b_q;
    reg  [7:0]  psw_q;
    reg  [7:0]  sp_q;
    reg  [15:0] data_pointer_q;
    reg         irq_seq_q;
    reg  [15:0] irq_vec_q;
    reg  [1:0]  irq_lvl_q;
    reg  [3:0]  active_q;

    wire [7:0]  op;
    wire [1:0]  len;
    wire [3:0]  last;
    wire        is_last;
    wire        exec;
    wire        take_irq;
    wire        fetch_now;
    wire        stall;
    wire [7:0]  o1;
    wire        rn_form;
    wire        ri_form;
    wire        bit_op;
    wire        movx_now;
    wire        movc_now;
    wire        store_now;
    wire        reti;
    wire [7:0]  byte_addr;
    wire [2:0]  bit_pos;
    wire        to_sfr;
    wire [7:0]  reg_addr;
    wire [7:0]  ptr;
    wire [7:0]  ram_b;
    wire [15:0] product;
    wire [7:0]  bit_mask;
    wire [2:0]  src_rank [0:`IRQ_COUNT-1];
    reg  [2:0]  best_rank;
    reg  [4:0]  best_idx;
    reg  [2:0]  cur_rank;
    reg  [3:0]  top_active;
    reg  [7:0]  ram_raddr;
    reg         ram_we;
    reg  [7:0]  ram_waddr;
    reg  [7:0]  ram_wdata;
    reg  [7:0]  sfr_val;
    reg  [7:0]  rd_val;
    reg         dw_en;
    reg  [7:0]  dw_data;
    integer     i;

    assign op       = (cnt_q == 3'd0) ? code_rdata : opcode_q;
    assign len      = instr_len(op);
    // every instruction ends after two clocks per machine cycle
    assign last     = irq_seq_q ? 4'd3 :
                      ({1'b0, instr_mcycles(op)} * `CLKS_PER_MCYCLE)
                      - 4'd1;
    assign is_last  = (cnt_q == last[2:0]);
    assign exec     = is_last && !irq_seq_q;
    assign take_irq = (cnt_q == 3'd0) && !irq_seq_q &&
                      irq_global_enable && (best_rank > cur_rank);
    assign fetch_now = !irq_seq_q && !take_irq &&
                       ({1'b0, cnt_q} < {2'b00, len});
    assign o1       = (cnt_q == 3'd1) ? code_rdata : op1_q;

    assign rn_form  = (op[7:5] == 3'b111) && op[3];
    assign ri_form  = (op[7:5] == 3'b111) && !op[3] && op[1];
    assign bit_op   = (op == `OP_SETB) || (op == `OP_CLR);
    assign reti     = !irq_seq_q && (op == `OP_RETI);
    assign movx_now = exec && (op[7:5] == 3'b111) && !op[3] && !op[2] &&
                      (op[1] || !op[0]);
    assign movc_now = exec && ((op == `OP_MOVC_DATA_POINTER) || (op == `OP_MOVC_PC));
    assign store_now = exec && (op == `OP_CODE_STORE);

    // indexed reads reach code only, base is pc or data pointer
    assign code_addr = movc_now ?
                       (((op == `OP_MOVC_PC) ? pc_q : data_pointer_q) +
                        {8'h00, acc_q}) :
                       (store_now ? data_pointer_q : pc_q);
    assign code_rd    = fetch_now || movc_now;
    assign code_wr    = store_now;
    assign code_wdata = acc_q;
    assign code_addr_backed = ~|code_addr[15:`CODE_ADDR_BITS];

    // MOVX @DATA_POINTER takes data_pointer, MOVX @Ri stays in page zero
    assign xdata_addr  = !op[1] ? data_pointer_q :
                         {`XDATA_PAGE, ptr};
    assign xdata_rd    = movx_now && !op[4];
    assign xdata_wr    = movx_now && op[4];
    assign xdata_wdata = acc_q;

    // slow memory holds the whole sequencer until it answers
    assign stall = ((code_rd || code_wr) && !code_ready) ||
                   ((xdata_rd || xdata_wr) && !xdata_ready);

    data_space_decoder u_decoder (
        .operand   (o1),
        .bit_mode  (bit_op),
        .bank      (psw_q[`PSW_BANK_HI:`PSW_BANK_LO]),
        .reg_sel   (op[3] ? op[2:0] : {2'b00, op[0]}),
        .byte_addr (byte_addr),
        .bit_pos   (bit_pos),
        .to_sfr    (to_sfr),
        .reg_addr  (reg_addr)
    );

    internal_data_ram u_internal_data_ram (
        .clk       (clk),
        .rd_a_addr (reg_addr),
        .rd_a_data (ptr),
        .rd_b_addr (ram_raddr),
        .rd_b_data (ram_b),
        .wr_en     (ram_we),
        .wr_addr   (ram_waddr),
        .wr_data   (ram_wdata)
    );

    assign product  = acc_q * b_q;
    assign bit_mask = 8'h01 << bit_pos;

    genvar g;
    generate
        for (g = 0; g < `IRQ_COUNT; g = g + 1) begin : g_rank
            assign src_rank[g] = !(irq_req[g] && irq_enable[g]) ? 3'd0 :
                irq_four_level ? {1'b0, irq_priority[2*g+1 -: 2]} + 3'd1 :
                {2'b00, irq_priority[2*g]} + 3'd1;
        end
    endgenerate

    always @* begin
        best_rank = 3'd0;
        best_idx  = 5'd0;
        // strict compare keeps the lowest source on a tie
        for (i = 0; i < `IRQ_COUNT; i = i + 1) begin
            if (src_rank[i] > best_rank) begin
                best_rank = src_rank[i];
                best_idx  = i[4:0];
            end
        end
        if (active_q[3]) begin
            cur_rank = 3'd4;
            top_active = 4'b1000;
        end else if (active_q[2]) begin
            cur_rank = 3'd3;
            top_active = 4'b0100;
        end else if (active_q[1]) begin
            cur_rank = 3'd2;
            top_active = 4'b0010;
        end else begin
            cur_rank = {2'b00, active_q[0]};
            top_active = {3'b000, active_q[0]};
        end
    end

    always @* begin
        case (byte_addr)
            `SFR_ACC: sfr_val = acc_q;
            `SFR_B:   sfr_val = b_q;
            `SFR_PSW: sfr_val = psw_q;
            `SFR_SP:  sfr_val = sp_q;
            `SFR_DPL: sfr_val = data_pointer_q[7:0];
            `SFR_DPH: sfr_val = data_pointer_q[15:8];
            default:  sfr_val = sfr_rdata;
        endcase
        // upper ram only through R0/R1 or the stack pointer, direct never reaches it
        if (reti)
            ram_raddr = (cnt_q == 3'd1) ? sp_q : sp_q - 8'd1;
        else if (ri_form)
            ram_raddr = ptr;
        else if (rn_form)
            ram_raddr = reg_addr;
        else
            ram_raddr = byte_addr;
        rd_val = (to_sfr && !rn_form && !ri_form) ? sfr_val : ram_b;
        dw_en = exec && ((op == `OP_MOV_DIR_A) || (op == `OP_MOV_D_IMM) ||
                         bit_op);
        if (op == `OP_MOV_DIR_A)
            dw_data = acc_q;
        else if (op == `OP_MOV_D_IMM)
            dw_data = op2_q;
        else if (op == `OP_SETB)
            dw_data = rd_val | bit_mask;
        else
            dw_data = rd_val & ~bit_mask;
        ram_we    = 1'b0;
        ram_waddr = byte_addr;
        ram_wdata = dw_data;
        if (take_irq) begin
            ram_we    = 1'b1;
            ram_waddr = sp_q + 8'd1;
            ram_wdata = pc_q[7:0];
        end else if (irq_seq_q && cnt_q == 3'd1) begin
            ram_we    = 1'b1;
            ram_waddr = sp_q + 8'd2;
            ram_wdata = pc_q[15:8];
        end else if (exec && rn_form && op[4]) begin
            ram_we    = 1'b1;
            ram_waddr = reg_addr;
            ram_wdata = acc_q;
        end else if (exec && ri_form && op[4] && op[2]) begin
            ram_we    = 1'b1;
            ram_waddr = ptr;
            ram_wdata = acc_q;
        end else if (dw_en && !to_sfr) begin
            ram_we = 1'b1;
        end
    end

    // internal sfrs stay inside, the rest go out one byte at a time
    assign sfr_addr  = byte_addr;
    assign sfr_wdata = dw_data;
    assign sfr_wr    = dw_en && to_sfr && !is_core_sfr(byte_addr) &&
                       !stall;
    assign sfr_rd    = exec && to_sfr && !is_core_sfr(byte_addr) &&
                       ((op == `OP_MOV_A_DIR) || bit_op);

    assign mcycle_phase = cnt_q[0];
    assign opcode_fetch = fetch_now && (cnt_q == 3'd0);
    assign irq_active   = active_q;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q     <= 3'd0;
            opcode_q  <= `OP_NOP;
            op1_q     <= 8'h00;
            op2_q     <= 8'h00;
            pc_q      <= `RESET_PC;
            acc_q     <= 8'h00;
            b_q       <= 8'h00;
            psw_q     <= 8'h00;
            sp_q      <= `RESET_SP;
            data_pointer_q    <= 16'h0000;
            irq_seq_q <= 1'b0;
            irq_vec_q <= 16'h0000;
            irq_lvl_q <= 2'd0;
            active_q  <= 4'h0;
        end else if (!stall) begin
            cnt_q <= is_last ? 3'd0 : cnt_q + 3'd1;
            if (cnt_q == 3'd0) begin
                if (take_irq) begin
                    irq_seq_q <= 1'b1;
                    irq_vec_q <= `VEC_BASE +
                                 {8'h00, best_idx, 3'b000};
                    irq_lvl_q <= best_rank[1:0] - 2'd1;
                end else begin
                    opcode_q <= code_rdata;
                end
            end
            if (fetch_now)
                pc_q <= pc_q + 16'd1;
            if (fetch_now && cnt_q == 3'd1)
                op1_q <= code_rdata;
            if (fetch_now && cnt_q == 3'd2)
                op2_q <= code_rdata;
            if (irq_seq_q && cnt_q == 3'd1)
                sp_q <= sp_q + 8'd2;
            if (irq_seq_q && is_last) begin
                pc_q      <= irq_vec_q;
                irq_seq_q <= 1'b0;
                active_q  <= active_q | (4'b0001 << irq_lvl_q);
            end
            if (reti && cnt_q == 3'd1)
                pc_q[15:8] <= ram_b;
            if (exec) begin
                case (op)
                    `OP_MOV_A_IMM: acc_q <= o1;
                    `OP_MOV_A_DIR: acc_q <= rd_val;
                    `OP_MOV_DATA_POINTER:  data_pointer_q <= {op1_q, op2_q};
                    `OP_INC_DATA_POINTER:  data_pointer_q <= data_pointer_q + 16'd1;
                    `OP_CODE_STORE: data_pointer_q <= data_pointer_q + 16'd1;
                    `OP_MOVC_DATA_POINTER, `OP_MOVC_PC: acc_q <= code_rdata;
                    `OP_LJMP:      pc_q <= {op1_q, op2_q};
                    `OP_MUL: begin
                        acc_q <= product[7:0];
                        b_q   <= product[15:8];
                        psw_q[`PSW_CY] <= 1'b0;
                        psw_q[`PSW_OV] <= |product[15:8];
                    end
                    `OP_RETI: begin
                        pc_q[7:0] <= ram_b;
                        sp_q      <= sp_q - 8'd2;
                        active_q  <= active_q & ~top_active;
                    end
                    default: begin
                        if ((rn_form || (ri_form && op[2])) && !op[4])
                            acc_q <= ram_b;
                        else if (movx_now && !op[4])
                            acc_q <= xdata_rdata;
                    end
                endcase
                if (dw_en && to_sfr) begin
                    case (byte_addr)
                        `SFR_ACC: acc_q <= dw_data;
                        `SFR_B:   b_q <= dw_data;
                        `SFR_PSW: psw_q <= dw_data;
                        `SFR_SP:  sp_q <= dw_data;
                        `SFR_DPL: data_pointer_q[7:0] <= dw_data;
                        `SFR_DPH: data_pointer_q[15:8] <= dw_data;
                        default:  acc_q <= acc_q;
                    endcase
                end
            end
        end
    end

endmodule // cpu_core

`default_nettype wire

//--- hdl/cpu_consts.vh
// cpu_consts.vh - shared constants of the 8-bit core
// assumes inclusion by the core and its data space decoder
`ifndef CPU_CONSTS_VH
`define CPU_CONSTS_VH

`define CLKS_PER_MCYCLE 4'd2
`define RESET_PC        16'h0000
`define RESET_SP        8'h07
`define VEC_BASE        16'h0003
`define IRQ_COUNT       24
`define CODE_ADDR_BITS  13
`define PSW_BANK_HI     4
`define PSW_BANK_LO     3
`define PSW_CY          7
`define PSW_OV          2
`define BIT_AREA_BASE   4'h2
`define XDATA_PAGE      8'h00

`define SFR_ACC         8'hE0
`define SFR_B           8'hF0
`define SFR_PSW         8'hD0
`define SFR_SP          8'h81
`define SFR_DPL         8'h82
`define SFR_DPH         8'h83

`define OP_NOP          8'h00
`define OP_LJMP         8'h02
`define OP_RETI         8'h32
`define OP_MOV_A_IMM    8'h74
`define OP_MOV_D_IMM    8'h75
`define OP_MOV_A_DIR    8'hE5
`define OP_MOV_DIR_A    8'hF5
`define OP_MOV_DATA_POINTER     8'h90
`define OP_INC_DATA_POINTER     8'hA3
`define OP_MOVX_RD_DP   8'hE0
`define OP_MOVX_WR_DP   8'hF0
`define OP_MOVC_DATA_POINTER    8'h93
`define OP_MOVC_PC      8'h83
`define OP_CODE_STORE   8'hA5
`define OP_MUL          8'hA4
`define OP_SETB         8'hD2
`define OP_CLR          8'hC2

`endif

//--- hdl/internal_data_ram.v
// internal_data_ram - 256 byte internal data ram with two read ports
// assumes one write per clock from the core; contents are not reset
`timescale 1ns/10ps
`default_nettype none

module internal_data_ram (
    input  wire       clk,
    input  wire [7:0] rd_a_addr,
    output wire [7:0] rd_a_data,
    input  wire [7:0] rd_b_addr,
    output wire [7:0] rd_b_data,
    input  wire       wr_en,
    input  wire [7:0] wr_addr,
    input  wire [7:0] wr_data
);

    // banks, bit area, lower and upper ram and the stack share this array
    reg [7:0] mem [0:255];

    assign rd_a_data = mem[rd_a_addr];
    assign rd_b_data = mem[rd_b_addr];

    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

endmodule // internal_data_ram

`default_nettype wire

//--- hdl/data_space_decoder.v
// data_space_decoder - maps direct, bit and register operands to bytes
// assumes combinational use by the core in the same clock
`timescale 1ns/10ps
`default_nettype none
`include "cpu_consts.vh"

module data_space_decoder (
    input  wire [7:0] operand,
    input  wire       bit_mode,
    input  wire [1:0] bank,
    input  wire [2:0] reg_sel,
    output wire [7:0] byte_addr,
    output wire [2:0] bit_pos,
    output wire       to_sfr,
    output wire [7:0] reg_addr
);

    // bits 00..7F live in the 16 bytes above the banks
    assign byte_addr = !bit_mode ? operand :
                       operand[7] ? {operand[7:3], 3'b000} :
                       {`BIT_AREA_BASE, operand[6:3]};
    assign bit_pos   = operand[2:0];
    // direct above 7F is the sfr space, never the upper ram
    assign to_sfr    = operand[7];
    // four banks of eight registers at consecutive bytes
    assign reg_addr  = {3'b000, bank, reg_sel};

endmodule // data_space_decoder

`default_nettype wire

//--- verification/cpu_core_sva.sv
// cpu_core_sva - port timing and decode checks of the core
// assumes binding onto cpu_core; one clock, async low reset
`timescale 1ns/10ps
`default_nettype none

module cpu_core_sva (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic [15:0] code_addr,
    input wire logic        code_rd,
    input wire logic        code_wr,
    input wire logic        code_ready,
    input wire logic        code_addr_backed,
    input wire logic [15:0] xdata_addr,
    input wire logic        xdata_rd,
    input wire logic        xdata_wr,
    input wire logic        xdata_ready,
    input wire logic [7:0]  sfr_addr,
    input wire logic        sfr_rd,
    input wire logic        sfr_wr,
    input wire logic        mcycle_phase,
    input wire logic        opcode_fetch,
    input wire logic [3:0]  irq_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic stall;
    assign stall = ((code_rd || code_wr) && !code_ready)
        || ((xdata_rd || xdata_wr) && !xdata_ready);

    phase_step_a: assert property (
        reset_n && !stall |=> mcycle_phase != $past(mcycle_phase))
        else $error("machine cycle phase did not advance");
    phase_hold_a: assert property (
        stall |=> $stable(mcycle_phase))
        else $error("phase moved during a wait");
    fetch_start_a: assert property (
        opcode_fetch |-> !mcycle_phase)
        else $error("opcode fetched in second clock");
    code_wait_a: assert property (
        code_rd && !code_ready |=> code_rd && $stable(code_addr))
        else $error("code request dropped during wait");
    data_wait_a: assert property (
        xdata_rd && !xdata_ready |=> xdata_rd && $stable(xdata_addr))
        else $error("data request dropped during wait");
    code_backed_a: assert property (
        code_addr_backed == (code_addr < 16'h2000))
        else $error("backed flag wrong");
    sfr_space_a: assert property (
        sfr_rd || sfr_wr |-> sfr_addr[7] && !(sfr_addr inside
        {8'hE0, 8'hF0, 8'hD0, 8'h81, 8'h82, 8'h83}))
        else $error("bad address on sfr path");
    sfr_phase_a: assert property (
        sfr_rd || sfr_wr |-> mcycle_phase)
        else $error("sfr strobe in first clock");
    data_phase_a: assert property (
        xdata_rd || xdata_wr |-> mcycle_phase)
        else $error("data access in first clock");
    reset_fetch_a: assert property (
        $rose(reset_n) |-> code_rd && code_addr == 16'h0000)
        else $error("first fetch not at zero");
    irq_vector_a: assert property (
        $rose(|irq_active) |-> ##[0:2] (opcode_fetch
        && code_addr[2:0] == 3'h3 && code_addr < 16'h00C0))
        else $error("interrupt entry missed its vector");
endmodule // cpu_core_sva

bind cpu_core cpu_core_sva cpu_core_sva_i (.clk, .reset_n, .code_addr,
    .code_rd, .code_wr, .code_ready, .code_addr_backed, .xdata_addr,
    .xdata_rd, .xdata_wr, .xdata_ready, .sfr_addr, .sfr_rd, .sfr_wr,
    .mcycle_phase, .opcode_fetch, .irq_active);
`default_nettype wire

//--- verification/mem_model.sv
// mem_model - code store, external data area and outside sfr bytes
// assumes async-read devices on the core clock; slow adds one wait
`timescale 1ns/10ps
`default_nettype none

module mem_model (
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire logic [15:0] code_addr,
    input  wire logic        code_rd,
    input  wire logic        code_wr,
    input  wire logic [7:0]  code_wdata,
    output logic      [7:0]  code_rdata,
    output logic             code_ready,
    input  wire logic [15:0] xdata_addr,
    input  wire logic        xdata_rd,
    input  wire logic        xdata_wr,
    input  wire logic [7:0]  xdata_wdata,
    output logic      [7:0]  xdata_rdata,
    output logic             xdata_ready,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_rd,
    input  wire logic        sfr_wr,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata
);
    logic [7:0] code_mem [0:8191];
    logic [7:0] xd_mem [0:255];
    logic [7:0] sfr_mem [0:255];
    logic       cw_q = 1'b0;
    logic       xw_q = 1'b0;
    logic [7:0] cb;
    assign cb = code_mem[code_addr[12:0]];
    // every code and xdata access waits one clock when slow
    assign code_ready = !slow || cw_q;
    assign xdata_ready = !slow || xw_q;
    // idle lines show the inverse, never the last byte
    assign code_rdata = code_rd ? cb : ~cb;
    assign xdata_rdata = xdata_rd ? xd_mem[xdata_addr[7:0]]
        : ~xd_mem[xdata_addr[7:0]];
    assign sfr_rdata = sfr_rd ? sfr_mem[sfr_addr] : ~sfr_mem[sfr_addr];
    always @(posedge clk) begin
        cw_q <= (code_rd || code_wr) && !code_ready;
        xw_q <= (xdata_rd || xdata_wr) && !xdata_ready;
        if (code_wr && code_ready)
            code_mem[code_addr[12:0]] <= code_wdata;
        if (xdata_wr && xdata_ready)
            xd_mem[xdata_addr[7:0]] <= xdata_wdata;
        if (sfr_wr)
            sfr_mem[sfr_addr] <= sfr_wdata;
    end
endmodule // mem_model
`default_nettype wire

//--- verification/cpu_core_tb.sv
// cpu_core_tb - program runs, wait states and interrupts on the core
// assumes mem_model on the far side and the bound port checker
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
    miscompares++; $display("Error at %0t: got %h expected %h", \
    $time, g, e); end end

module cpu_core_tb;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        slow = 1'b0;
    logic [23:0] irq_req = 24'h000000;
    logic [23:0] irq_enable = 24'h000000;
    logic        irq_global_enable = 1'b0;
    logic [47:0] irq_priority = 48'h000000000000;
    logic        irq_four_level = 1'b0;
    logic [15:0] code_addr, xdata_addr;
    logic [7:0]  code_wdata, code_rdata, xdata_wdata, xdata_rdata;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
    logic [3:0]  irq_active;
    logic        code_rd, code_wr, code_ready, code_addr_backed;
    logic        xdata_rd, xdata_wr, xdata_ready;
    logic        sfr_rd, sfr_wr, mcycle_phase, opcode_fetch;
    int          miscompares = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          fc [0:255];

    cpu_core cpu_core_i (.clk, .reset_n, .irq_req, .irq_enable,
        .irq_global_enable, .irq_priority, .irq_four_level, .code_addr,
        .code_rd, .code_wr, .code_wdata, .code_rdata, .code_ready,
        .code_addr_backed, .xdata_addr, .xdata_rd, .xdata_wr,
        .xdata_wdata, .xdata_rdata, .xdata_ready, .sfr_addr, .sfr_rd,
        .sfr_wr, .sfr_wdata, .sfr_rdata, .mcycle_phase, .opcode_fetch,
        .irq_active);
    mem_model mem_model_i (.clk, .slow, .code_addr, .code_rd, .code_wr,
        .code_wdata, .code_rdata, .code_ready, .xdata_addr, .xdata_rd,
        .xdata_wr, .xdata_wdata, .xdata_rdata, .xdata_ready, .sfr_addr,
        .sfr_rd, .sfr_wr, .sfr_wdata, .sfr_rdata);

    initial forever #20 clk = ~clk;
    // clock count of each opcode fetch, by low address byte
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (opcode_fetch && code_ready)
            fc[code_addr[7:0]] <= cyc;
    end

    function automatic logic [7:0] sf(input logic [7:0] a);
        return mem_model_i.sfr_mem[a];
    endfunction

    task automatic ld(input int a, input int n, input logic [151:0] v);
        for (int i = 0; i < n; i++)
            mem_model_i.code_mem[a + i] = v[8 * (n - 1 - i) +: 8];
    endtask

    task automatic boot(input logic s);
        @(posedge clk);
        reset_n <= 1'b0;
        slow <= s;
        for (int i = 0; i < 8192; i++)
            mem_model_i.code_mem[i] = 8'h00;
        for (int i = 0; i < 256; i++) begin
            mem_model_i.sfr_mem[i] = 8'h00;
            mem_model_i.xd_mem[i] = 8'h00;
        end
        ld('h00, 3, 24'h020040);
        ld('h13, 5, 40'h7455F5A832);
        ld('h2B, 5, 40'h7466F5A732);
        ld('h40, 16, 128'h75D008A474A5F8F5A0E508F5A17490F9);
        ld('h50, 16, 128'h743CF7E590F5A2E7F5A3900100F0A5E0);
        ld('h60, 19, 152'hF5A4740393F5A5752000D207E520F5A6020070);
        mem_model_i.code_mem[13'h0104] = 8'h96;
        mem_model_i.sfr_mem[8'h90] = 8'h5A;
        mem_model_i.xd_mem[8'h01] = 8'hC3;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
    endtask

    task automatic wait_fetch(input logic [15:0] a);
        for (int i = 0; i < 2000; i++) begin
            @(posedge clk);
            #1;
            if (opcode_fetch === 1'b1 && code_addr === a)
                break;
        end
        `CHK(code_addr, a)
    endtask

    task automatic wait_irq(input logic [3:0] e);
        for (int i = 0; i < 500; i++) begin
            @(posedge clk);
            #1;
            if (irq_active === e)
                break;
        end
    endtask

    task automatic chk_prog;
        wait_fetch(16'h0070);
        `CHK(sf(8'hA0), 8'hA5)
        `CHK(sf(8'hA1), 8'hA5)
        `CHK(sf(8'hA2), 8'h5A)
        `CHK(sf(8'hA3), 8'h3C)
        `CHK(sf(8'h90), 8'h5A)
        `CHK(sf(8'hD0), 8'h00)
        `CHK(sf(8'hA4), 8'hC3)
        `CHK(sf(8'hA5), 8'h96)
        `CHK(sf(8'hA6), 8'h80)
        `CHK(mem_model_i.xd_mem[8'h00], 8'h3C)
        `CHK(mem_model_i.code_mem[13'h0100], 8'h3C)
    endtask

    task automatic t_slow;
        boot(1'b1);
        chk_prog();
        $display("test slow memory done");
    endtask

    task automatic t_fast;
        boot(1'b0);
        chk_prog();
        `CHK(fc[8'h40] - fc[8'h00], 4)
        `CHK(fc[8'h43] - fc[8'h40], 4)
        `CHK(fc[8'h44] - fc[8'h43], 8)
        `CHK(fc[8'h46] - fc[8'h44], 2)
        `CHK(fc[8'h47] - fc[8'h46], 2)
        $display("test program timing done");
    endtask

    task automatic t_irq;
        @(posedge clk);
        irq_enable <= 24'h000024;
        irq_priority <= 48'h000000000400;
        irq_global_enable <= 1'b1;
        irq_req <= 24'h0000A4;
        wait_irq(4'b0010);
        `CHK(irq_active, 4'b0010)
        wait_irq(4'b0000);
        `CHK(sf(8'hA7), 8'h66)
        `CHK(sf(8'hA8), 8'h00)
        @(posedge clk);
        irq_req <= 24'h000084;
        wait_irq(4'b0001);
        `CHK(irq_active, 4'b0001)
        @(posedge clk);
        irq_req <= 24'h000080;
        wait_irq(4'b0000);
        repeat (20) @(posedge clk);
        `CHK(irq_active, 4'b0000)
        `CHK(sf(8'hA8), 8'h55)
        // four-level scheme: source 2 at level 3
        irq_four_level <= 1'b1;
        irq_priority <= 48'h000000000030;
        irq_req <= 24'h000004;
        wait_irq(4'b1000);
        `CHK(irq_active, 4'b1000)
        @(posedge clk);
        irq_req <= 24'h000000;
        wait_irq(4'b0000);
        `CHK(irq_active, 4'b0000)
        $display("test interrupts done");
    endtask

    task automatic give_verdict;
        $display("comparisons %0d miscompares %0d", comparisons,
            miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        t_slow();
        t_fast();
        t_irq();
        give_verdict();
    end

    // about 300 clocks expected; cut a hang well beyond that
    initial begin
        #400000;
        miscompares++;
        give_verdict();
    end
endmodule // cpu_core_tb
`default_nettype wire
